// File: inc/deep_sleep_pkg.sv
package deep_sleep_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] OFS_SETTLE = 4'h0;
   localparam logic [3:0] OFS_CFG    = 4'h4;
   localparam logic [3:0] OFS_CMD    = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   // Oscillation settle select: the wait is 2**(base + select) cycles
   localparam int         SETTLE_SEL_W = 3;
   localparam logic [2:0] SETTLE_RST   = 3'h4;
   localparam logic [2:0] SETTLE_MAX   = 3'h4;

   // Peripheral clock source configuration bits
   localparam int        CFG_TM16_WATCH = 0;
   localparam int        CFG_WATCH_SUB  = 1;
   localparam int        CFG_TM8_EXT    = 2;
   localparam int        CFG_RTO_TRIG   = 3;
   localparam int        CFG_SIO_EXT    = 4;
   localparam int        CFG_W          = 5;
   localparam logic [4:0] CFG_RST       = 5'h00;

   // Command bit: write 1 executes the deep sleep instruction
   localparam int CMD_SLEEP = 0;

   // Status fields
   localparam int ST_STATE   = 0;
   localparam int ST_CAUSE   = 2;
   localparam int ST_REFUSED = 4;
   localparam int ST_PENDING = 5;

   typedef enum logic [1:0] {ST_RUN, ST_DEEP, ST_LIGHT, ST_SETTLE} sleep_state_e;
   typedef enum logic [1:0] {WK_NONE, WK_IRQ, WK_TEST, WK_RESET} wake_cause_e;

endpackage

// File: src/settle_timer.sv
`timescale 1ns/1ns
module settle_timer #(
   parameter int W = 18
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Control
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   // Status
   output logic              busy,
   output logic              done
);

   logic [W-1:0] count_q;
   logic         done_q;

   generate
      if (W < 2)
      begin : g_chk
         $error("settle_timer needs at least two counter bits");
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         count_q <= '0;
      else if (start)
         count_q <= load;
      else if (count_q != '0)
         count_q <= count_q - W'(1);
   end

   // Done marks the edge at which the loaded number of cycles has passed
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         done_q <= 1'b0;
      else
         done_q <= !start && (count_q == W'(1));
   end

   assign busy = (count_q != '0);
   assign done = done_q;

endmodule // settle_timer

// File: src/deep_sleep_standby_control.sv
`timescale 1ns/1ns
// Summary of operation
// - Deep sleep is entered by the instruction only while running on main clock.
// - Crystal output pin is pulled to supply; not for external main clock systems.
// - A pending unmasked interrupt at entry drops the device into light sleep.
// - From that light sleep, operation resumes after the programmed settle wait.
// - Deep sleep stops only the main oscillator and halts the CPU.
// - Port latches and expansion address lines keep their pre-sleep values.
// - 16-bit timer runs only on watch output with watch on subsystem clock.
// - 8-bit timers run only when counting the external timer inputs.
// - Watch timer runs only when clocked from a present subsystem clock.
// - Real-time output runs only on external trigger or external 8-bit timer clocks.
// - Serial units run only on external clock; automatic unit and UART stop.
// - An unmasked interrupt request wakes the device from deep sleep.
// - After settling, take the vector if acknowledge is enabled, else continue.
// - An unmasked test input wakes the device from deep sleep.
// - After test wake and settling, continue with the next instruction, no vector.
// - Reset input wakes the device; reset follows the stabilization time.
module deep_sleep_standby_control #(
   parameter int IRQ_N       = 8,
   parameter int TEST_N      = 1,
   parameter int SETTLE_BASE = 13
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Avalon-MM slave
   input  wire logic [3:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   // CPU and interrupt controller
   input  wire logic             cpu_on_main_clk,
   input  wire logic             sub_clk_present,
   input  wire logic [IRQ_N-1:0] irq_req,
   input  wire logic [IRQ_N-1:0] irq_mask,
   input  wire logic             irq_ack_en,
   input  wire logic [TEST_N-1:0] test_mask,
   // Pins
   input  wire logic [TEST_N-1:0] test_in,
   input  wire logic             rst_pin_n,
   // Wake results
   output logic                  resume_pulse,
   output logic                  vector_pulse,
   output logic                  reset_req,
   // Clock and pin control
   output logic                  main_osc_stop,
   output logic                  xtal_pullup,
   output logic                  cpu_halt,
   output logic                  latch_hold,
   output logic                  bus_park,
   // Peripheral run enables
   output logic                  tm16_run,
   output logic                  tm8_run,
   output logic                  watch_run,
   output logic                  wdt_run,
   output logic                  adc_run,
   output logic                  dac_run,
   output logic                  rto_run,
   output logic                  sio_run,
   output logic                  auto_sio_uart_run,
   output logic                  ext_irq_zero_en,
   output logic                  ext_irq_one_to_five_en
);

   localparam int CNT_W = SETTLE_BASE + 5;

   generate
      if (SETTLE_BASE < 1 || SETTLE_BASE > 24 || IRQ_N < 1 || IRQ_N > 24 || TEST_N < 1)
      begin : g_chk
         $error("deep_sleep_standby_control: parameter out of range");
      end
   endgenerate

   // Settle selects above the largest legal code behave as the largest
   function automatic logic [CNT_W-1:0] settle_cycles(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > deep_sleep_pkg::SETTLE_MAX) ? deep_sleep_pkg::SETTLE_MAX : sel;
      return CNT_W'(1) << (SETTLE_BASE + int'(s));
   endfunction

   logic                                         ack_q;
   logic                                         req;
   logic                                         wr_en;
   logic [deep_sleep_pkg::SETTLE_SEL_W-1:0]      settle_sel_q;
   logic [deep_sleep_pkg::CFG_W-1:0]             cfg_q;
   logic                                         refused_q;
   deep_sleep_pkg::sleep_state_e                 state_q;
   deep_sleep_pkg::wake_cause_e                  cause_q;
   logic [TEST_N-1:0]                            test_s1_q;
   logic [TEST_N-1:0]                            test_s2_q;
   logic                                         rst_s1_q;
   logic                                         rst_s2_q;
   logic                                         sleep_cmd;
   logic                                         pending;
   logic                                         test_wake;
   logic                                         rst_wake;
   logic                                         deep;
   logic                                         tmr_start;
   logic [CNT_W-1:0]                             tmr_load;
   logic                                         tmr_busy;
   logic                                         tmr_done;

   // Bus slave: one wait cycle, so read data can come from a flip-flop
   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !ack_q;
   assign wr_en           = avs_write && ack_q && avs_byteenable[0];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ack_q <= 1'b0;
      else
         ack_q <= req && !ack_q;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && !ack_q)
      begin
         avs_readdata <= 32'h0000_0000;
         unique case (avs_address)
            deep_sleep_pkg::OFS_SETTLE:
               avs_readdata[2:0] <= settle_sel_q;
            deep_sleep_pkg::OFS_CFG:
               avs_readdata[deep_sleep_pkg::CFG_W-1:0] <= cfg_q;
            deep_sleep_pkg::OFS_STATUS:
            begin
               avs_readdata[deep_sleep_pkg::ST_STATE +: 2] <= state_q;
               avs_readdata[deep_sleep_pkg::ST_CAUSE +: 2] <= cause_q;
               avs_readdata[deep_sleep_pkg::ST_REFUSED]    <= refused_q;
               avs_readdata[deep_sleep_pkg::ST_PENDING]    <= pending;
            end
            default:
               avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         settle_sel_q <= deep_sleep_pkg::SETTLE_RST;
      else if (wr_en && avs_address == deep_sleep_pkg::OFS_SETTLE)
         settle_sel_q <= avs_writedata[2:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cfg_q <= deep_sleep_pkg::CFG_RST;
      else if (wr_en && avs_address == deep_sleep_pkg::OFS_CFG)
         cfg_q <= avs_writedata[deep_sleep_pkg::CFG_W-1:0];
   end

   assign sleep_cmd = wr_en && (avs_address == deep_sleep_pkg::OFS_CMD)
                      && avs_writedata[deep_sleep_pkg::CMD_SLEEP];

   // Sticky refusal of a sleep attempt off the main clock; a new refusal beats the clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         refused_q <= 1'b0;
      else if (state_q == deep_sleep_pkg::ST_RUN && sleep_cmd && !cpu_on_main_clk)
         refused_q <= 1'b1;
      else if (wr_en && avs_address == deep_sleep_pkg::OFS_STATUS
               && avs_writedata[deep_sleep_pkg::ST_REFUSED])
         refused_q <= 1'b0;
   end

   // Pin synchronisers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         test_s1_q <= '0;
         test_s2_q <= '0;
         rst_s1_q  <= 1'b1;
         rst_s2_q  <= 1'b1;
      end
      else
      begin
         test_s1_q <= test_in;
         test_s2_q <= test_s1_q;
         rst_s1_q  <= rst_pin_n;
         rst_s2_q  <= rst_s1_q;
      end
   end

   assign pending   = |(irq_req & ~irq_mask);
   assign test_wake = |(test_s2_q & ~test_mask);
   assign rst_wake  = !rst_s2_q;
   assign deep      = (state_q == deep_sleep_pkg::ST_DEEP);

   // Sleep sequencer
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_q <= deep_sleep_pkg::ST_RUN;
      else
      begin
         unique case (state_q)
            deep_sleep_pkg::ST_RUN:
               if (sleep_cmd && cpu_on_main_clk)
                  state_q <= pending ? deep_sleep_pkg::ST_LIGHT
                                     : deep_sleep_pkg::ST_DEEP;
            deep_sleep_pkg::ST_DEEP:
               if (rst_wake || pending || test_wake)
                  state_q <= deep_sleep_pkg::ST_SETTLE;
            deep_sleep_pkg::ST_LIGHT:
               if (tmr_done)
                  state_q <= deep_sleep_pkg::ST_RUN;
            deep_sleep_pkg::ST_SETTLE:
               if (tmr_done)
                  state_q <= deep_sleep_pkg::ST_RUN;
         endcase
      end
   end

   // Reset outranks an interrupt, which outranks a test input
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cause_q <= deep_sleep_pkg::WK_NONE;
      else if (deep && rst_wake)
         cause_q <= deep_sleep_pkg::WK_RESET;
      else if (deep && pending)
         cause_q <= deep_sleep_pkg::WK_IRQ;
      else if (deep && test_wake)
         cause_q <= deep_sleep_pkg::WK_TEST;
   end

   // Reset wake always waits the reset stabilization time, not the software select
   assign tmr_start = (deep && (rst_wake || pending || test_wake))
                      || (state_q == deep_sleep_pkg::ST_RUN && sleep_cmd
                          && cpu_on_main_clk && pending);
   assign tmr_load  = (deep && rst_wake) ? settle_cycles(deep_sleep_pkg::SETTLE_RST)
                                         : settle_cycles(settle_sel_q);

   settle_timer #(
      .W     (CNT_W)
   ) u_settle (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (tmr_start),
      .load    (tmr_load),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   // Wake results, one cycle each, at the return to run
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         resume_pulse <= 1'b0;
         vector_pulse <= 1'b0;
         reset_req    <= 1'b0;
      end
      else
      begin
         resume_pulse <= tmr_done && (state_q == deep_sleep_pkg::ST_LIGHT
                         || (state_q == deep_sleep_pkg::ST_SETTLE
                             && (cause_q == deep_sleep_pkg::WK_TEST
                                 || (cause_q == deep_sleep_pkg::WK_IRQ && !irq_ack_en))));
         vector_pulse <= tmr_done && state_q == deep_sleep_pkg::ST_SETTLE
                         && cause_q == deep_sleep_pkg::WK_IRQ && irq_ack_en;
         reset_req    <= tmr_done && state_q == deep_sleep_pkg::ST_SETTLE
                         && cause_q == deep_sleep_pkg::WK_RESET;
      end
   end

   // Clock, pin and bus control
   assign main_osc_stop = deep;
   assign xtal_pullup   = deep;
   assign cpu_halt      = (state_q != deep_sleep_pkg::ST_RUN);
   assign latch_hold    = deep;
   assign bus_park      = deep;

   // Peripheral gating; outside deep sleep everything runs
   assign tm16_run  = !deep || (cfg_q[deep_sleep_pkg::CFG_TM16_WATCH]
                     && cfg_q[deep_sleep_pkg::CFG_WATCH_SUB] && sub_clk_present);
   assign tm8_run   = !deep || cfg_q[deep_sleep_pkg::CFG_TM8_EXT];
   assign watch_run = !deep || (cfg_q[deep_sleep_pkg::CFG_WATCH_SUB]
                     && sub_clk_present);
   assign rto_run   = !deep || cfg_q[deep_sleep_pkg::CFG_RTO_TRIG]
                     || cfg_q[deep_sleep_pkg::CFG_TM8_EXT];
   assign sio_run   = !deep || cfg_q[deep_sleep_pkg::CFG_SIO_EXT];
   assign auto_sio_uart_run      = !deep;
   assign wdt_run                = !deep;
   assign adc_run                = !deep;
   assign dac_run                = 1'b1;
   assign ext_irq_zero_en        = !deep;
   assign ext_irq_one_to_five_en = 1'b1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   entry_main_a: assert property (
      state_q == deep_sleep_pkg::ST_RUN && sleep_cmd && !cpu_on_main_clk
      |=> state_q == deep_sleep_pkg::ST_RUN && refused_q)
      else $error("sleep entered off the main clock");

   fallback_light_a: assert property (
      state_q == deep_sleep_pkg::ST_RUN && sleep_cmd && cpu_on_main_clk && pending
      |=> state_q == deep_sleep_pkg::ST_LIGHT && tmr_busy)
      else $error("pending interrupt did not force light sleep");

   light_hold_a: assert property (
      state_q == deep_sleep_pkg::ST_LIGHT && !tmr_done
      |=> state_q == deep_sleep_pkg::ST_LIGHT && !resume_pulse)
      else $error("light sleep left before settle wait");

   deep_pins_a: assert property (
      state_q == deep_sleep_pkg::ST_RUN && sleep_cmd && cpu_on_main_clk && !pending
      |=> main_osc_stop && xtal_pullup && cpu_halt && latch_hold && bus_park
          && !ext_irq_zero_en && !wdt_run && !adc_run && dac_run)
      else $error("deep sleep pin state wrong");

   tm16_gate_a: assert property (
      deep && !sub_clk_present |-> !tm16_run && !watch_run)
      else $error("timer runs without subsystem clock");

   irq_wake_a: assert property (
      deep && pending && rst_s2_q
      |=> state_q == deep_sleep_pkg::ST_SETTLE && cause_q == deep_sleep_pkg::WK_IRQ
      ##1 tmr_busy)
      else $error("unmasked interrupt did not wake");

   vector_take_a: assert property (
      state_q == deep_sleep_pkg::ST_SETTLE && tmr_done
      && cause_q == deep_sleep_pkg::WK_IRQ && irq_ack_en
      |=> vector_pulse && !resume_pulse && state_q == deep_sleep_pkg::ST_RUN)
      else $error("vector not taken after interrupt wake");

   test_resume_a: assert property (
      state_q == deep_sleep_pkg::ST_SETTLE && tmr_done && cause_q == deep_sleep_pkg::WK_TEST
      |=> resume_pulse && !vector_pulse ##1 !resume_pulse)
      else $error("test wake did not resume plainly");

   reset_wake_a: assert property (
      deep && !rst_s2_q |=> cause_q == deep_sleep_pkg::WK_RESET && !reset_req)
      else $error("reset input did not wake");

   deep_cover_c: cover property (deep && pending);
   light_cover_c: cover property (state_q == deep_sleep_pkg::ST_LIGHT && tmr_done);
   reset_cover_c: cover property (reset_req);

endmodule // deep_sleep_standby_control

// File: verification/deep_sleep_standby_control_bench.sv
`timescale 1ns/1ns
module deep_sleep_standby_control_bench;
   // Short settle base keeps every wait in tens of cycles
   localparam int BASE = 2;
   logic        clk;
   logic        sys_rst;
   logic [3:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cpu_on_main_clk;
   logic        sub_clk_present;
   logic        irq_ack_en;
   logic        rst_pin_n;
   logic [7:0]  irq_req;
   logic [7:0]  irq_mask;
   logic [0:0]  test_mask;
   logic [0:0]  test_in;
   logic        resume_pulse, vector_pulse, reset_req;
   logic        main_osc_stop, xtal_pullup, cpu_halt, latch_hold, bus_park;
   logic        tm16_run, tm8_run, watch_run, wdt_run, adc_run, dac_run;
   logic        rto_run, sio_run, auto_sio_uart_run;
   logic        ext_irq_zero_en, ext_irq_one_to_five_en;
   logic [10:0] run_vec;
   logic [4:0]  ctl_vec;
   logic [2:0]  wake_vec;
   logic [31:0] rd;
   int          fails = 0;
   int          comparisons = 0;
   int          cycles = 0;

   assign run_vec  = {tm16_run, tm8_run, watch_run, wdt_run, adc_run, dac_run, rto_run,
                      sio_run, auto_sio_uart_run, ext_irq_zero_en, ext_irq_one_to_five_en};
   assign ctl_vec  = {main_osc_stop, xtal_pullup, cpu_halt, latch_hold, bus_park};
   assign wake_vec = {reset_req, vector_pulse, resume_pulse};

   deep_sleep_standby_control #(.IRQ_N(8), .TEST_N(1), .SETTLE_BASE(BASE)) u_dut (
      .clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_on_main_clk(cpu_on_main_clk), .sub_clk_present(sub_clk_present),
      .irq_req(irq_req), .irq_mask(irq_mask), .irq_ack_en(irq_ack_en),
      .test_mask(test_mask), .test_in(test_in), .rst_pin_n(rst_pin_n),
      .resume_pulse(resume_pulse), .vector_pulse(vector_pulse), .reset_req(reset_req),
      .main_osc_stop(main_osc_stop), .xtal_pullup(xtal_pullup), .cpu_halt(cpu_halt),
      .latch_hold(latch_hold), .bus_park(bus_park),
      .tm16_run(tm16_run), .tm8_run(tm8_run), .watch_run(watch_run), .wdt_run(wdt_run),
      .adc_run(adc_run), .dac_run(dac_run), .rto_run(rto_run), .sio_run(sio_run),
      .auto_sio_uart_run(auto_sio_uart_run), .ext_irq_zero_en(ext_irq_zero_en),
      .ext_irq_one_to_five_en(ext_irq_one_to_five_en)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Whole run needs about 350 cycles, far below the 20000-cycle budget that stops a hang
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails++;
         $display("CHECK FAILED at %0t: timeout", $time);
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Waitrequest is sampled at the rising edge, before the slave's flops update there
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic bus_rd(input logic [3:0] a);
      @(posedge clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // Expected run enables inside deep sleep for a clock-source setting
   function automatic logic [10:0] deep_run(input logic [4:0] c, input logic s);
      logic ws;
      ws = c[deep_sleep_pkg::CFG_WATCH_SUB] & s;
      deep_run = {c[deep_sleep_pkg::CFG_TM16_WATCH] & ws, c[deep_sleep_pkg::CFG_TM8_EXT], ws,
                  3'b001, c[deep_sleep_pkg::CFG_RTO_TRIG] | c[deep_sleep_pkg::CFG_TM8_EXT],
                  c[deep_sleep_pkg::CFG_SIO_EXT], 3'b001};
   endfunction

   task automatic wait_wake(input logic [2:0] exp, input int lo, input int hi);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (wake_vec === 3'b000 && n < hi + 20);
      check(32'(wake_vec), 32'(exp), "wake result");
      check(32'(n >= lo && n <= hi), 32'h1, "settle wait");
      check(32'(ctl_vec), 32'h0, "control after wake");
      check(32'(run_vec), 32'h7ff, "run enables after wake");
   endtask

   logic [4:0] cfg_tab [4] = '{5'h00, 5'h1f, 5'h03, 5'h14};
   logic       sub_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic [1:0] cause_tab [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
   logic [2:0] wake_tab [4] = '{3'b010, 3'b001, 3'b001, 3'b100};

   initial
   begin
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_byteenable = 4'hf;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      cpu_on_main_clk = 1'b1;
      sub_clk_present = 1'b1;
      irq_ack_en = 1'b0;
      rst_pin_n = 1'b1;
      irq_req = 8'h00;
      irq_mask = 8'hff;
      test_mask = 1'b1;
      test_in = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      bus_rd(deep_sleep_pkg::OFS_SETTLE);
      check(rd, {29'h0, deep_sleep_pkg::SETTLE_RST}, "settle reset value");
      bus_rd(deep_sleep_pkg::OFS_CFG);
      check(rd, 32'h0, "cfg reset value");
      bus_rd(deep_sleep_pkg::OFS_STATUS);
      check(rd, 32'h0, "status reset value");
      bus_rd(4'h2);
      check(rd, 32'h0, "unmapped read");
      check(32'(run_vec), 32'h7ff, "run enables after reset");
      bus_wr(deep_sleep_pkg::OFS_SETTLE, 32'h1, 4'he);
      bus_rd(deep_sleep_pkg::OFS_SETTLE);
      check(rd, 32'h4, "lane 0 disabled write");
      // Entry off the main clock must be refused
      @(posedge clk);
      cpu_on_main_clk <= 1'b0;
      bus_wr(deep_sleep_pkg::OFS_CMD, 32'h1, 4'hf);
      repeat (3) @(posedge clk);
      #1;
      check(32'(ctl_vec), 32'h0, "no sleep off main clock");
      bus_rd(deep_sleep_pkg::OFS_STATUS);
      check({26'h0, rd[5:0]}, 32'h10, "refused flag");
      cpu_on_main_clk <= 1'b1;
      bus_wr(deep_sleep_pkg::OFS_STATUS, 32'h10, 4'hf);
      // Pending unmasked request at entry: light sleep, select above 4 acts as 4
      bus_wr(deep_sleep_pkg::OFS_SETTLE, 32'h7, 4'hf);
      irq_req <= 8'h01;
      irq_mask <= 8'hfe;
      bus_rd(deep_sleep_pkg::OFS_STATUS);
      check({26'h0, rd[5:0]}, 32'h20, "pending set, refused cleared");
      bus_wr(deep_sleep_pkg::OFS_CMD, 32'h1, 4'hf);
      @(posedge clk);
      #1;
      check(32'(ctl_vec), 32'h4, "light sleep keeps main oscillator");
      wait_wake(3'b001, 60, 70);
      @(posedge clk);
      irq_req <= 8'h00;
      irq_mask <= 8'hff;
      bus_wr(deep_sleep_pkg::OFS_SETTLE, 32'h0, 4'hf);
      for (int k = 0; k < 4; k++)
      begin
         sub_clk_present <= sub_tab[k];
         bus_wr(deep_sleep_pkg::OFS_CFG, {27'h0, cfg_tab[k]}, 4'hf);
         bus_wr(deep_sleep_pkg::OFS_CMD, 32'h1, 4'hf);
         @(posedge clk);
         #1;
         check(32'(ctl_vec), 32'h1f, "deep sleep controls");
         check(32'(run_vec), 32'(deep_run(cfg_tab[k], sub_tab[k])), "deep run");
         bus_rd(deep_sleep_pkg::OFS_STATUS);
         check({30'h0, rd[1:0]}, 32'h1, "deep state");
         // Masked sources must leave the device asleep
         @(posedge clk);
         irq_req <= 8'h01;
         test_in <= 1'b1;
         repeat (8) @(posedge clk);
         #1;
         check(32'(ctl_vec), 32'h1f, "masked sources hold sleep");
         @(posedge clk);
         irq_ack_en <= (k == 0);
         if (k < 2)
            irq_mask <= 8'hfe;
         else
            irq_req <= 8'h00;
         if (k == 2)
            test_mask <= 1'b0;
         else
            test_in <= 1'b0;
         if (k == 3)
            rst_pin_n <= 1'b0;
         if (k == 3)
            wait_wake(wake_tab[k], 64, 76);
         else
            wait_wake(wake_tab[k], 4, 16);
         @(posedge clk);
         irq_req <= 8'h00;
         irq_mask <= 8'hff;
         test_in <= 1'b0;
         test_mask <= 1'b1;
         rst_pin_n <= 1'b1;
         repeat (4) @(posedge clk);
         bus_rd(deep_sleep_pkg::OFS_STATUS);
         check({28'h0, rd[3:0]}, {28'h0, cause_tab[k], 2'b00}, "wake cause");
      end
      print_verdict();
   end

endmodule // deep_sleep_standby_control_bench
